//--- logic/cktm_clock_timer.sv
`timescale 1ns/1ps
`default_nettype none

module cktm_clock_timer #(
  parameter int unsigned ADDR_W = cktm_pkg::ADDR_W,
  parameter int unsigned DATA_W = cktm_pkg::DATA_W
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              tick_256hz,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   timer_irq
);

  // ------------------------------------------------------------
  // divider chain
  // ------------------------------------------------------------
  cktm_div_if dv ();

  cktm_divider #(
    .WIDTH (cktm_pkg::DIV_W)
  ) u_divider (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .dv       (dv)
  );

  // tick comes from the oscillator divider on this clock, so no resync
  assign dv.tick = tick_256hz;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  cktm_pkg::cktm_bus_e           bus_q;
  cktm_pkg::cktm_bus_e           bus_d;
  logic                          wait_q;
  logic                          wait_d;
  logic [DATA_W-1:0]             rdata_q;
  logic [DATA_W-1:0]             rdata_d;
  logic [cktm_pkg::SRC_N-1:0]    mask_q;
  logic [cktm_pkg::SRC_N-1:0]    mask_d;
  logic [cktm_pkg::SRC_N-1:0]    flag_q;
  logic [cktm_pkg::SRC_N-1:0]    flag_d;
  logic                          restart_q;
  logic                          restart_d;
  logic                          irq_q;
  logic                          irq_d;

  // decode helpers
  logic [cktm_pkg::IDX_W-1:0]    idx;
  logic                          req;
  logic                          done;
  logic                          lane0;
  logic [cktm_pkg::SRC_N-1:0]    fall_vec;
  logic [cktm_pkg::SRC_N-1:0]    rd_clear;

  assign idx   = avs_address[cktm_pkg::IDX_LO +: cktm_pkg::IDX_W];
  assign req   = avs_read | avs_write;
  // the transfer completes at the edge where waitrequest is seen low
  assign done  = req & ~wait_q;
  assign lane0 = avs_byteenable[0];

  assign fall_vec[cktm_pkg::BIT_32] = dv.fall_32;
  assign fall_vec[cktm_pkg::BIT_8]  = dv.fall_8;
  assign fall_vec[cktm_pkg::BIT_2]  = dv.fall_2;

  // ------------------------------------------------------------
  // bus handshake: one wait cycle, then a one-cycle answer
  // ------------------------------------------------------------
  // read data is captured on the first edge so it stands during the answer
  always_comb begin
    bus_d   = bus_q;
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    case (bus_q)
      cktm_pkg::BUS_IDLE: begin
        if (req) begin
          bus_d  = cktm_pkg::BUS_ACK;
          wait_d = 1'b0;
          rdata_d = cktm_pkg::DATA_ZERO;
          if (avs_read) begin
            if (idx == cktm_pkg::IDX_TAP_VALUE) begin
              rdata_d[cktm_pkg::TAP_W-1:0] = dv.taps[cktm_pkg::TAP_HI:cktm_pkg::TAP_LO];
            end else if (idx == cktm_pkg::IDX_ENABLES) begin
              rdata_d[cktm_pkg::SRC_N-1:0] = mask_q;
            end else if (idx == cktm_pkg::IDX_FLAGS) begin
              rdata_d[cktm_pkg::SRC_N-1:0] = flag_q;
            end else begin
              rdata_d = cktm_pkg::DATA_ZERO; // strobe and unmapped read zero
            end
          end
        end
      end
      cktm_pkg::BUS_ACK: begin
        bus_d  = cktm_pkg::BUS_IDLE;
        wait_d = 1'b1;
      end
      default: begin
        bus_d  = cktm_pkg::BUS_IDLE;
        wait_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus_q   <= cktm_pkg::BUS_IDLE;
      wait_q  <= 1'b1;
      rdata_q <= cktm_pkg::DATA_ZERO;
    end else begin
      bus_q   <= bus_d;
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------
  // enables, flags, restart strobe, request
  // ------------------------------------------------------------
  // a read clears exactly what it returned, so a flag raised after the
  // capture edge survives; a new edge in the clear cycle also wins
  always_comb begin
    mask_d    = mask_q;
    restart_d = 1'b0;
    rd_clear  = '0;
    if (done && avs_write && lane0) begin
      if (idx == cktm_pkg::IDX_ENABLES) begin
        mask_d = avs_writedata[cktm_pkg::SRC_N-1:0];
      end else if (idx == cktm_pkg::IDX_RESTART) begin
        restart_d = avs_writedata[cktm_pkg::BIT_RST];
      end
      // tap value and flag writes fall through untouched
    end
    if (done && avs_read && (idx == cktm_pkg::IDX_FLAGS)) begin
      rd_clear = rdata_q[cktm_pkg::SRC_N-1:0];
    end
    flag_d = (flag_q & ~rd_clear) | fall_vec;
    irq_d  = |(flag_q & mask_q);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mask_q    <= cktm_pkg::SRC_RST;
      flag_q    <= cktm_pkg::SRC_RST;
      restart_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      mask_q    <= mask_d;
      flag_q    <= flag_d;
      restart_q <= restart_d;
      irq_q     <= irq_d;
    end
  end

  assign dv.restart      = restart_q;
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign timer_irq       = irq_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  wait_answer_a: assert property (
    ((bus_q == cktm_pkg::BUS_IDLE) && req) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");

  tap_read_a: assert property (
    ((bus_q == cktm_pkg::BUS_IDLE) && avs_read && (idx == cktm_pkg::IDX_TAP_VALUE))
    |=> (avs_readdata == {28'h000_0000, $past(dv.taps[6:3])}))
    else $error("tap value read wrong");

  mask_reset_a: assert property (
    !$past(rst_n) |-> ((mask_q == cktm_pkg::SRC_RST) && (flag_q == cktm_pkg::SRC_RST)))
    else $error("mask or flags not cleared by reset");

  mask_write_a: assert property (
    (done && avs_write && lane0 && (idx == cktm_pkg::IDX_ENABLES))
    |=> (mask_q == $past(avs_writedata[2:0])))
    else $error("mask write lost");

  flag_set_a: assert property (
    (dv.fall_32 || dv.fall_2) |=> (flag_q[0] || !$past(dv.fall_32))
                                  && (flag_q[2] || !$past(dv.fall_2)))
    else $error("falling edge did not set flag");

  irq_gate_a: assert property (
    1'b1 |=> (timer_irq == (|($past(flag_q) & $past(mask_q)))))
    else $error("interrupt request not gated by mask");

  flag_rdclr_a: assert property (
    (done && avs_read && (idx == cktm_pkg::IDX_FLAGS) && rdata_q[1] && !dv.fall_8)
    |=> !flag_q[1])
    else $error("read did not clear returned flag");

  strobe_zero_a: assert property (
    ((bus_q == cktm_pkg::BUS_IDLE) && avs_read && (idx == cktm_pkg::IDX_RESTART))
    |=> (avs_readdata == 32'h0000_0000))
    else $error("restart strobe read not zero");

  restart_chain_a: assert property (
    (done && avs_write && lane0 && (idx == cktm_pkg::IDX_RESTART) && avs_writedata[2])
    |=> dv.restart ##1 (dv.taps == 7'h00))
    else $error("restart write did not clear divider");

  flag_nowr_a: assert property (
    (done && avs_write && (idx == cktm_pkg::IDX_FLAGS) && !dv.fall_32 && flag_q[0] == 1'b0)
    |=> !flag_q[0])
    else $error("flag write changed flag");

  // read-back of enables and flags, upper bits forced to zero
  mask_rd_a: assert property (
    ((bus_q == cktm_pkg::BUS_IDLE) && avs_read && (idx == cktm_pkg::IDX_ENABLES))
    |=> (avs_readdata == {{(DATA_W - cktm_pkg::SRC_N){1'b0}}, $past(mask_q)}))
    else $error("enable read-back wrong");

  flag_rd_a: assert property (
    ((bus_q == cktm_pkg::BUS_IDLE) && avs_read && (idx == cktm_pkg::IDX_FLAGS))
    |=> (avs_readdata == {{(DATA_W - cktm_pkg::SRC_N){1'b0}}, $past(flag_q)}))
    else $error("flag read-back wrong");

  // the enables move only on a completed write to their own address
  mask_hold_a: assert property (
    !(done && avs_write && lane0 && (idx == cktm_pkg::IDX_ENABLES))
    |=> $stable(mask_q))
    else $error("enables changed without a write");

  flag_mask_a: assert property (
    (done && avs_write && lane0 && (idx == cktm_pkg::IDX_ENABLES) && (fall_vec == '0))
    |=> (flag_q == $past(flag_q)))
    else $error("enable write disturbed flags");

  // a flag only rises after a stage fell, and only a flag read drops it
  flag_cause_a: assert property (
    ((flag_q & ~$past(flag_q) & ~$past(fall_vec)) == '0))
    else $error("flag set without falling edge");

  flag_stay_a: assert property (
    !(done && avs_read && (idx == cktm_pkg::IDX_FLAGS))
    |=> ((flag_q & $past(flag_q)) == $past(flag_q)))
    else $error("flag cleared without a read");

  // request follows flag and enable in both directions
  irq_off_a: assert property (
    (mask_q == '0) |=> !timer_irq)
    else $error("request raised with every source masked");

  irq_on_a: assert property (
    (|(flag_q & mask_q)) |=> timer_irq)
    else $error("request missing for an enabled flag");

  // restart strobe: one pulse per written 1, nothing for a 0
  restart_noop_a: assert property (
    (done && avs_write && (idx == cktm_pkg::IDX_RESTART) && !avs_writedata[cktm_pkg::BIT_RST])
    |=> !dv.restart)
    else $error("restart fired on a written zero");

  restart_once_a: assert property (
    dv.restart |=> !dv.restart)
    else $error("restart pulse longer than one cycle");

  tap_wr_a: assert property (
    (done && avs_write && (idx == cktm_pkg::IDX_TAP_VALUE) && !dv.tick && !dv.restart)
    |=> $stable(dv.taps))
    else $error("tap write disturbed divider");

  tap_reset_a: assert property (
    !$past(rst_n) |-> ((dv.taps == cktm_pkg::DIV_RST) && !timer_irq))
    else $error("divider or request not cleared by reset");

  // handshake idle behaviour: no answer and stale data kept without a request
  wait_idle_a: assert property (
    ((bus_q == cktm_pkg::BUS_IDLE) && !req) |=> avs_waitrequest)
    else $error("waitrequest dropped without a request");

  rdata_hold_a: assert property (
    !((bus_q == cktm_pkg::BUS_IDLE) && req) |=> $stable(avs_readdata))
    else $error("read data changed without a request");

endmodule

`default_nettype wire

//--- logic/cktm_div_if.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// link between register front end and divider chain
// ------------------------------------------------------------
interface cktm_div_if;
  logic                       tick;     // 256 Hz enable, one cycle
  logic                       restart;  // clear chain, one cycle
  logic [cktm_pkg::DIV_W-1:0] taps;     // all seven stages
  logic                       fall_32;
  logic                       fall_8;
  logic                       fall_2;

  modport div (input tick, input restart, output taps, output fall_32, output fall_8,
               output fall_2);
  modport ctl (output tick, output restart, input taps, input fall_32, input fall_8,
               input fall_2);
endinterface

`default_nettype wire

//--- logic/cktm_divider.sv
`timescale 1ns/1ps
`default_nettype none

module cktm_divider #(
  parameter int unsigned WIDTH = cktm_pkg::DIV_W
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  cktm_div_if.div   dv
);

  // ------------------------------------------------------------
  // counter and previous-stage copy
  // ------------------------------------------------------------
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] prev_d;

  // restart beats the tick so the chain always starts from zero
  always_comb begin
    count_d = count_q;
    if (dv.restart) begin
      count_d = cktm_pkg::DIV_RST;
    end else if (dv.tick) begin
      count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
    prev_d = count_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count_q <= cktm_pkg::DIV_RST;
      prev_q  <= cktm_pkg::DIV_RST;
    end else begin
      count_q <= count_d;
      prev_q  <= prev_d;
    end
  end

  // falling edge = high last cycle, low now
  assign dv.taps    = count_q;
  assign dv.fall_32 = prev_q[cktm_pkg::STG_32] & ~count_q[cktm_pkg::STG_32];
  assign dv.fall_8  = prev_q[cktm_pkg::STG_8]  & ~count_q[cktm_pkg::STG_8];
  assign dv.fall_2  = prev_q[cktm_pkg::STG_2]  & ~count_q[cktm_pkg::STG_2];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  count_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dv.tick && !dv.restart) |=> (count_q == $past(count_q) + 1'b1))
    else $error("divider did not advance on tick");

  count_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!dv.tick && !dv.restart) |=> $stable(count_q))
    else $error("divider moved without tick");

  restart_clr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    dv.restart |=> (count_q == '0))
    else $error("restart did not clear divider");

  fall_det_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($past(count_q[cktm_pkg::STG_8]) && !count_q[cktm_pkg::STG_8]) |-> dv.fall_8)
    else $error("8 Hz falling edge missed");

endmodule

`default_nettype wire

//--- logic/cktm_pkg.sv
package cktm_pkg;

  // ------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;   // byte address, word index in [9:2]
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 8;
  localparam int unsigned IDX_LO = 2;    // byte address = 4 * index

  // register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_TAP_VALUE = 8'he4;
  localparam logic [IDX_W-1:0] IDX_ENABLES   = 8'heb;
  localparam logic [IDX_W-1:0] IDX_FLAGS     = 8'hef;
  localparam logic [IDX_W-1:0] IDX_RESTART   = 8'hf9;

  // ------------------------------------------------------------
  // divider chain layout
  // ------------------------------------------------------------
  localparam int unsigned DIV_W   = 7;   // stage k runs at 128 Hz >> k
  localparam int unsigned TAP_LO  = 3;   // 16 Hz stage
  localparam int unsigned TAP_HI  = 6;   // 2 Hz stage
  localparam int unsigned TAP_W   = 4;
  localparam int unsigned STG_32  = 2;
  localparam int unsigned STG_8   = 4;
  localparam int unsigned STG_2   = 6;

  // event / enable field positions
  localparam int unsigned SRC_N   = 3;
  localparam int unsigned BIT_32  = 0;
  localparam int unsigned BIT_8   = 1;
  localparam int unsigned BIT_2   = 2;
  localparam int unsigned BIT_RST = 2;   // restart strobe position

  // reset values
  localparam logic [DIV_W-1:0]  DIV_RST   = 7'h00;
  localparam logic [SRC_N-1:0]  SRC_RST   = 3'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // bus handshake states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } cktm_bus_e;

endpackage

//--- testbench/cktm_clock_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module cktm_clock_timer_tb_top;
  localparam logic [9:0] A_TAP = {cktm_pkg::IDX_TAP_VALUE, 2'b00};
  localparam logic [9:0] A_MSK = {cktm_pkg::IDX_ENABLES, 2'b00};
  localparam logic [9:0] A_FLG = {cktm_pkg::IDX_FLAGS, 2'b00};
  localparam logic [9:0] A_RST = {cktm_pkg::IDX_RESTART, 2'b00};
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        tick_256hz = 1'b0;
  logic [9:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        timer_irq;
  logic [6:0]  cnt = 7'h00;   // expected divider chain
  logic [2:0]  ef = 3'h0;     // expected event flags
  logic [2:0]  mk = 3'h0;     // expected enables
  int          mismatches = 0;
  int          total_checks = 0;
  int          cyc = 0;

  always #5 core_clk = ~core_clk;

  cktm_clock_timer cktm_clock_timer_inst (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .tick_256hz      (tick_256hz),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .timer_irq       (timer_irq)
  );

  cktm_cpu_model cktm_cpu_model_inst (
    .core_clk        (core_clk),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic report_and_stop;
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    cktm_cpu_model_inst.xfer(1'b0, a, 32'h0000_0000, 4'hf, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    cktm_cpu_model_inst.xfer(1'b1, a, d, be, q);
  endtask

  // ticks on consecutive cycles; falls of the 32, 8 and 2 hz stages noted
  task automatic tick_n(input int n);
    logic [6:0] nx;
    for (int i = 0; i < n; i++) begin
      nx = cnt + 7'h01;
      ef = ef | {cnt[6] & ~nx[6], cnt[4] & ~nx[4], cnt[2] & ~nx[2]};
      cnt = nx;
      @(posedge core_clk);
      tick_256hz <= 1'b1;
    end
    @(posedge core_clk);
    tick_256hz <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  // every enable pattern against the standing flags
  task automatic sweep;
    for (int m = 0; m < 8; m++) begin
      mk = 3'(m);
      wr(A_MSK, {29'h0, mk}, 4'hf);
      repeat (3) @(posedge core_clk);
      chk({31'h0, timer_irq}, {31'h0, |(ef & mk)});
      rd(A_MSK, {29'h0, mk});
    end
  endtask

  // hang guard, a few thousand cycles is ample for this sequence
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(A_TAP, 32'h0);
    rd(A_MSK, 32'h0);
    rd(A_FLG, 32'h0);
    rd(A_RST, 32'h0);
    rd(10'h000, 32'h0);
    wr(A_MSK, 32'hffff_ffff, 4'hf);
    rd(A_MSK, 32'h7);
    wr(A_MSK, 32'h0, 4'h0);
    rd(A_MSK, 32'h7);
    wr(A_MSK, 32'h0, 4'hf);
    mk = 3'h0;
    tick_n(16);
    chk({31'h0, timer_irq}, 32'h0);
    sweep();
    wr(A_TAP, 32'hffff_ffff, 4'hf);
    rd(A_TAP, {28'h0, cnt[6:3]});
    wr(A_FLG, 32'hffff_ffff, 4'hf);
    rd(A_FLG, {29'h0, ef});
    ef = 3'h0;
    rd(A_FLG, 32'h0);
    wr(A_FLG, 32'hffff_ffff, 4'hf);
    rd(A_FLG, 32'h0);
    // walk past a full wrap, reading taps and flags on the way
    for (int i = 0; i < 10; i++) begin
      tick_n(13);
      rd(A_TAP, {28'h0, cnt[6:3]});
      chk({31'h0, timer_irq}, {31'h0, |ef});
      rd(A_FLG, {29'h0, ef});
      ef = 3'h0;
      repeat (2) @(posedge core_clk);
      chk({31'h0, timer_irq}, 32'h0);
    end
    tick_n(7'h7f - cnt);
    rd(A_FLG, {29'h0, ef});
    ef = 3'h0;
    wr(A_RST, 32'hffff_fffb, 4'hf);
    rd(A_TAP, 32'hf);
    wr(A_RST, 32'h0000_0004, 4'hf);
    ef = 3'h7;
    cnt = 7'h00;
    repeat (3) @(posedge core_clk);
    rd(A_TAP, 32'h0);
    rd(A_RST, 32'h0);
    sweep();
    rd(A_FLG, 32'h7);
    ef = 3'h0;
    tick_n(9);
    rd(A_TAP, 32'h1);
    report_and_stop();
  end
endmodule

`default_nettype wire

//--- testbench/cktm_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// cpu side of the register bus
// ------------------------------------------------------------
module cktm_cpu_model (
  input  wire logic        core_clk,
  output logic [9:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  // idle bus at time zero
  initial begin
    avs_address    = 10'h000;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end

  // one transfer; no wait count assumed, the bench timeout bounds a stall
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    @(posedge core_clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= ~wr;
    avs_write      <= wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read       <= 1'b0;
    avs_write      <= 1'b0;
    // released lines show the inverse so stale values never pass for data
    avs_address    <= ~a;
    avs_writedata  <= ~d;
    avs_byteenable <= ~be;
  endtask
endmodule

`default_nettype wire
